// File: common/rpx_map.svh
// Named constants of the parity engine: modes, block size, pad layout.
// Assumes inclusion by the package and the engine; definitions only.
`ifndef RPX_MAP_SVH
`define RPX_MAP_SVH

// ------------------------------------------------------------
// Operation select codes
// ------------------------------------------------------------
`define RPX_MODE_IDLE   2'h0
`define RPX_MODE_COPY   2'h1
`define RPX_MODE_XOR    2'h2
`define RPX_MODE_WBACK  2'h3

// ------------------------------------------------------------
// Sizes and counts
// ------------------------------------------------------------
`define RPX_SRAM_AW     20
`define RPX_BUF_AW      11
`define RPX_BUF_WORDS   2048
`define RPX_XFER_INIT   11'h080
`define RPX_XFER_ONE    11'h001
`define RPX_SRAM_ONE    20'h00001
`define RPX_BUF_ONE     11'h001
`define RPX_BURST_MASK  2'h3
`define RPX_BURST_HEAD  2'h0
`define RPX_RD_CAP      1
`define RPX_RD_VLD      2

// ------------------------------------------------------------
// Memory data pads: 36 lines, four unused parity positions
// ------------------------------------------------------------
`define RPX_PAD_W       36
`define RPX_WORD_W      32
`define RPX_PAR3        35
`define RPX_PAR2        26
`define RPX_PAR1        17
`define RPX_PAR0        8

`endif

// File: common/rpx_pkg.sv
// Types of the parity engine; the buffer uses none of them.
// Assumes rpx_map.svh is on the include path.
`include "rpx_map.svh"

package rpx_pkg;

  // ------------------------------------------------------------
  // Sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    RPX_ST_IDLE  = 5'h01,
    RPX_ST_LOAD  = 5'h02,
    RPX_ST_RUN   = 5'h04,
    RPX_ST_DRAIN = 5'h08,
    RPX_ST_DONE  = 5'h10
  } rpx_state_type;

  // ------------------------------------------------------------
  // One block request as captured at the pads
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 mode;
    logic [`RPX_SRAM_AW-1:0]    sram_base;
    logic [`RPX_BUF_AW-1:0]     buf_base;
  } rpx_req_type;

  // Memory strobes, all active low
  typedef struct packed {
    logic ce_n;
    logic adv_n;
    logic oe_n;
    logic we_n;
  } rpx_strobe_type;

endpackage : rpx_pkg

// File: dv/rpx_engine_asserts.sv
// Checker for the parity engine: memory pad strobes, data lines, done.
// Assumes it is bound to rpx_engine and sees only that module's ports.
`include "rpx_map.svh"

module rpx_engine_asserts (
  input wire logic                    core_clk,
  input wire logic                    reset,
  input wire logic                    start,
  input wire logic                    operation_done,
  input wire logic                    memory_clock_out,
  input wire logic                    bus_request,
  input wire logic                    bus_read,
  input wire logic [`RPX_SRAM_AW-1:0] mem_addr,
  input wire logic                    mem_ce_n,
  input wire logic                    mem_adv_n,
  input wire logic                    mem_oe_n,
  input wire logic                    mem_we_n,
  input wire logic [`RPX_PAD_W-1:0]   mem_dq_out,
  input wire logic                    mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Memory side, sampled where the memory itself samples
  // ------------------------------------------------------------
  parity_low_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    !mem_we_n |-> mem_dq_oe && !(mem_dq_out[35] | mem_dq_out[26] | mem_dq_out[17] | mem_dq_out[8]))
    else $error("write cycle without pad drive or with parity lines high");
  burst_len_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    (!mem_ce_n && mem_adv_n) |=> !mem_adv_n [*3])
    else $error("burst head not followed by three advances");
  burst_end_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    !mem_adv_n [*3] |=> mem_adv_n)
    else $error("burst longer than four words");
  // Back-to-back heads must step by exactly one burst of four
  addr_step_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    (!mem_ce_n && mem_adv_n) ##4 (!mem_ce_n && mem_adv_n) |-> mem_addr == $past(mem_addr, 4) + 20'h4)
    else $error("burst start address not linear");
  bus_req_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    (!mem_ce_n || !mem_adv_n) |-> bus_request)
    else $error("memory strobe without bus request");
  rd_dir_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    !mem_oe_n |-> bus_read && mem_we_n)
    else $error("output enable outside a read operation");
  wr_dir_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    !mem_we_n |-> !bus_read && mem_oe_n)
    else $error("write strobe outside a write back");
  oe_dir_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    mem_dq_oe |-> !bus_read)
    else $error("pads driven during a read operation");
  idle_done_a : assert property (@(posedge memory_clock_out) disable iff (reset)
    operation_done |-> mem_ce_n && mem_oe_n && mem_we_n)
    else $error("memory strobe active while done");

  // ------------------------------------------------------------
  // User side: done holds until a new start is seen
  // ------------------------------------------------------------
  done_hold_a : assert property (@(posedge core_clk) disable iff (reset)
    operation_done && !start && !$past(start) |=> operation_done)
    else $error("done dropped without a start");

endmodule : rpx_engine_asserts

// File: dv/rpx_engine_tb_top.sv
// Testbench for the parity engine: copy, xor, write back, idle mode.
// Assumes the SRAM model answers on memory_clock_out with feedback looped.
`include "rpx_map.svh"

module rpx_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, mem_clk = 1'b0, reset, ref_clock_locked, start;
  logic memory_clock_feedback, operation_done, memory_clock_out, bus_request, bus_read;
  logic [19:0] sram_block_base, mem_addr;
  logic [10:0] buffer_block_base;
  logic [1:0]  operation_select;
  logic        mem_ce_n, mem_adv_n, mem_oe_n, mem_we_n, mem_dq_oe;
  logic [35:0] mem_dq_in, mem_dq_out;
  int          err_total = 0, checks = 0, dh, dw;

  assign memory_clock_feedback = memory_clock_out;

  // Clocks: core 4 ns, link 48 ns with an unrelated phase
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #7;
    forever #24 mem_clk = ~mem_clk;
  end

  rpx_engine DUT (.core_clk, .reset, .ref_clock_locked, .mem_clk, .memory_clock_feedback,
    .sram_block_base, .buffer_block_base, .operation_select, .start, .operation_done,
    .memory_clock_out, .bus_request, .bus_read, .mem_addr, .mem_ce_n, .mem_adv_n,
    .mem_oe_n, .mem_we_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);

  rpx_sram_model mem_model (.clk(memory_clock_out), .ce_n(mem_ce_n), .adv_n(mem_adv_n),
    .we_n(mem_we_n), .addr(mem_addr), .dq_out(mem_dq_out), .dq_oe(mem_dq_oe),
    .dq_in(mem_dq_in));

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // One block operation; start held six cycles, done awaited with a bound
  task automatic run_op(logic [1:0] m, logic [19:0] s, logic [10:0] b);
    int n, h0, w0;
    h0 = mem_model.heads;
    w0 = mem_model.writes;
    operation_select = m;
    sram_block_base = s;
    buffer_block_base = b;
    start = 1'b1;
    repeat (6) @(negedge core_clk);
    start = 1'b0;
    n = 0;
    while (m != 2'h0 && operation_done !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20000) begin
      err_total++;
      $display("Error done wait expected 1 seen %b", operation_done);
      stop_test();
    end
    // Idle mode gives no done edge, so let a full block time pass
    if (m == 2'h0) repeat (4000) @(negedge core_clk);
    // A few quiet cycles so done is watched while it stands
    repeat (4) @(negedge core_clk);
    if (m != 2'h0) check("done held", 32'h1, operation_done);
    dh = mem_model.heads - h0;
    dw = mem_model.writes - w0;
    $display("operation %0h finished", m);
  endtask : run_op

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    ref_clock_locked = 1'b0;
    start = 1'b0;
    operation_select = 2'h0;
    sram_block_base = 20'h00000;
    buffer_block_base = 11'h000;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    // Lock comes late so the memory side sees a long internal reset
    repeat (80) @(negedge core_clk);
    ref_clock_locked = 1'b1;
    repeat (150) @(negedge core_clk);
    run_op(2'h1, 20'h00000, 11'h000);
    check("copy bursts", 32'h20, dh);
    check("copy writes", 32'h0, dw);
    run_op(2'h2, 20'h00080, 11'h000);
    check("xor bursts", 32'h20, dh);
    run_op(2'h3, 20'h00200, 11'h000);
    check("wback writes", 32'h80, dw);
    for (int i = 0; i < 128; i++)
      check("xor word", mem_model.init_word(i) ^ mem_model.init_word(i + 128),
            mem_model.mem[512 + i]);
    check("word past block", mem_model.init_word(640), mem_model.mem[640]);
    // Last buffer region, reached through both port counters
    run_op(2'h1, 20'h00100, 11'h780);
    run_op(2'h3, 20'h00300, 11'h780);
    for (int i = 0; i < 128; i++)
      check("copy word", mem_model.init_word(256 + i), mem_model.mem[768 + i]);
    run_op(2'h0, 20'h00000, 11'h000);
    check("idle bursts", 32'h0, dh);
    check("idle writes", 32'h0, dw);
    check("idle done", 32'h0, operation_done);
    stop_test();
  end

endmodule : rpx_engine_tb_top

bind rpx_engine rpx_engine_asserts u_chk (.core_clk, .reset, .start, .operation_done,
  .memory_clock_out, .bus_request, .bus_read, .mem_addr, .mem_ce_n, .mem_adv_n, .mem_oe_n,
  .mem_we_n,
  .mem_dq_out, .mem_dq_oe);

// File: dv/rpx_sram_model.sv
// Behavioural burst SRAM standing at the engine's memory pads.
// Assumes linear bursts and one cycle of pipelined read latency.
module rpx_sram_model (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        adv_n,
  input  wire logic        we_n,
  input  wire logic [19:0] addr,
  input  wire logic [35:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [35:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [19:0] ptr_q;
  logic [31:0] pipe_q;
  logic        pipe_vld_q;
  int          heads = 0;
  int          writes = 0;

  function automatic logic [31:0] init_word(int i);
    return {16'h5a3c ^ i[15:0], i[15:0]};
  endfunction : init_word

  // Distinct preload so misplaced words show up
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = init_word(i);
    dq_in = 36'h0;
    pipe_vld_q = 1'b0;
  end

  // Head loads address, advances step linearly; idle bus toggles
  always @(posedge clk) begin
    logic [19:0] a;
    a = (!ce_n && adv_n) ? addr : ptr_q + 20'h1;
    if (!ce_n && adv_n) heads++;
    if (!ce_n || !adv_n) ptr_q <= a;
    // Data leaves one clock after its address; parity lines read as ones
    if (pipe_vld_q)
      dq_in <= {1'b1, pipe_q[31:24], 1'b1, pipe_q[23:16],
                1'b1, pipe_q[15:8], 1'b1, pipe_q[7:0]};
    else
      dq_in <= ~dq_in;
    pipe_vld_q <= (!ce_n || !adv_n) && we_n;
    pipe_q     <= mem[a[9:0]];
    if ((!ce_n || !adv_n) && !we_n && dq_oe) begin
      mem[a[9:0]] <= {dq_out[34:27], dq_out[25:18], dq_out[16:9], dq_out[7:0]};
      writes++;
    end
  end

endmodule : rpx_sram_model

// File: verilog/rpx_buffer.sv
// Dual-port 2K x 32 xor buffer, flip-flop storage, synchronous reads.
// Assumes both ports are clocked by the memory-side clock of the engine.
`include "rpx_map.svh"

module rpx_buffer (
  input  wire logic                      clk,
  input  wire logic                      a_en,
  input  wire logic                      a_we,
  input  wire logic [`RPX_BUF_AW-1:0]    a_adr,
  input  wire logic                      b_en,
  input  wire logic                      b_we,
  input  wire logic [`RPX_BUF_AW-1:0]    b_adr,
  input  wire logic [`RPX_WORD_W-1:0]    b_wdata,
  input  wire logic [`RPX_WORD_W-1:0]    sram_q,
  output logic      [`RPX_WORD_W-1:0]    a_dout,
  output logic      [`RPX_WORD_W-1:0]    b_dout
);

  logic [`RPX_WORD_W-1:0] mem_q [`RPX_BUF_WORDS];
  logic [`RPX_WORD_W-1:0] a_wdata;

  // ------------------------------------------------------------
  // Xor path
  // ------------------------------------------------------------
  // Old contents from port B folded with registered memory data
  assign a_wdata = b_dout ^ sram_q;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Both ports may write; the sequencer never aims them at one word
  always_ff @(posedge clk) begin
    if (a_en && a_we) begin
      mem_q[a_adr] <= a_wdata;
    end
    if (b_en && b_we) begin
      mem_q[b_adr] <= b_wdata;
    end
  end

  // Read-before-write on each port, one cycle latency
  always_ff @(posedge clk) begin
    if (a_en) begin
      a_dout <= mem_q[a_adr];
    end
    if (b_en) begin
      b_dout <= mem_q[b_adr];
    end
  end

endmodule : rpx_buffer

// File: verilog/rpx_engine.sv
// Parity and regeneration engine: block moves between burst SRAM
// and the xor buffer. Assumes the clock managers sit outside and
// report lock; mem_clk is the de-skewed memory-side clock.
`include "rpx_map.svh"

module rpx_engine (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      ref_clock_locked,
  input  wire logic                      mem_clk,
  input  wire logic                      memory_clock_feedback,
  input  wire logic [`RPX_SRAM_AW-1:0]   sram_block_base,
  input  wire logic [`RPX_BUF_AW-1:0]    buffer_block_base,
  input  wire logic [1:0]                operation_select,
  input  wire logic                      start,
  output logic                           operation_done,
  output logic                           memory_clock_out,
  output logic                           bus_request,
  output logic                           bus_read,
  output logic      [`RPX_SRAM_AW-1:0]   mem_addr,
  output logic                           mem_ce_n,
  output logic                           mem_adv_n,
  output logic                           mem_oe_n,
  output logic                           mem_we_n,
  input  wire logic [`RPX_PAD_W-1:0]     mem_dq_in,
  output logic      [`RPX_PAD_W-1:0]     mem_dq_out,
  output logic                           mem_dq_oe
);

  // ------------------------------------------------------------
  // Pad helpers
  // ------------------------------------------------------------
  // Strip the four parity lines from a 36-bit pad word
  function automatic logic [`RPX_WORD_W-1:0] pad_to_word(
    input logic [`RPX_PAD_W-1:0] pad
  );
    pad_to_word = {pad[`RPX_PAR3-1:`RPX_PAR2+1], pad[`RPX_PAR2-1:`RPX_PAR1+1],
                   pad[`RPX_PAR1-1:`RPX_PAR0+1], pad[`RPX_PAR0-1:0]};
  endfunction : pad_to_word

  // Spread a word over the pads, parity lines driven low
  function automatic logic [`RPX_PAD_W-1:0] word_to_pad(
    input logic [`RPX_WORD_W-1:0] w
  );
    word_to_pad = {1'b0, w[31:24], 1'b0, w[23:16], 1'b0, w[15:8], 1'b0, w[7:0]};
  endfunction : word_to_pad

  // ------------------------------------------------------------
  // Core domain: reset, pad capture, start and done
  // ------------------------------------------------------------
  logic                 lock_s1_q;
  logic                 lock_s2_q;
  logic                 core_rst_q;
  rpx_pkg::rpx_req_type req_s1_q;
  rpx_pkg::rpx_req_type req_q;
  logic                 start_s1_q;
  logic                 start_s2_q;
  logic                 start_prev_q;
  logic                 go_tgl_q;
  logic                 done_s1_q;
  logic                 done_s2_q;
  logic                 done_prev_q;
  logic                 done_tgl_q;

  // Lock arrives from another clock, so it is synchronised first
  always_ff @(posedge core_clk) begin
    lock_s1_q <= ref_clock_locked;
    lock_s2_q <= lock_s1_q;
  end

  // Internal reset stays high until the reference manager locks
  always_ff @(posedge core_clk) begin
    core_rst_q <= reset | ~lock_s2_q;
  end

  // User inputs pass two pad flops before anything reads them
  always_ff @(posedge core_clk) begin
    req_s1_q   <= '{mode: operation_select, sram_base: sram_block_base,
                    buf_base: buffer_block_base};
    req_q      <= req_s1_q;
    start_s1_q <= start;
    start_s2_q <= start_s1_q;
  end

  // Rising start becomes a toggle; idle mode is dropped here
  always_ff @(posedge core_clk) begin
    if (core_rst_q) begin
      start_prev_q <= 1'b0;
      go_tgl_q     <= 1'b0;
    end else begin
      start_prev_q <= start_s2_q;
      if (start_s2_q && !start_prev_q && req_q.mode != `RPX_MODE_IDLE) begin
        go_tgl_q <= ~go_tgl_q;
      end
    end
  end

  // Done toggle from the memory side, two flops then edge detect
  always_ff @(posedge core_clk) begin
    if (core_rst_q) begin
      done_s1_q   <= 1'b0;
      done_s2_q   <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      done_s1_q   <= done_tgl_q;
      done_s2_q   <= done_s1_q;
      done_prev_q <= done_s2_q;
    end
  end

  // Done stands until the next start; completion wins over a clear
  always_ff @(posedge core_clk) begin
    if (core_rst_q) begin
      operation_done <= 1'b0;
    end else if (done_s2_q != done_prev_q) begin
      operation_done <= 1'b1;
    end else if (start_s2_q && !start_prev_q) begin
      operation_done <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Memory domain: reset, clock out, phase
  // ------------------------------------------------------------
  logic mrst_s1_q;
  logic mrst_s2_q;
  logic fb_s1_q;
  logic fb_s2_q;
  logic fb_prev_q;
  logic fb_seen_q;
  logic mrst_q;
  logic mphase_q;

  // Core reset and board feedback both cross in through two flops
  always_ff @(posedge mem_clk) begin
    mrst_s1_q <= core_rst_q;
    mrst_s2_q <= mrst_s1_q;
    fb_s1_q   <= memory_clock_feedback;
    fb_s2_q   <= fb_s1_q;
    fb_prev_q <= fb_s2_q;
  end

  // Memory side waits for the feedback loop to show activity
  always_ff @(posedge mem_clk) begin
    if (mrst_s2_q) begin
      fb_seen_q <= 1'b0;
      mrst_q    <= 1'b1;
    end else begin
      if (fb_s2_q != fb_prev_q) begin
        fb_seen_q <= 1'b1;
      end
      mrst_q <= ~fb_seen_q;
    end
  end

  // Memory clock is mem_clk halved; pads move on the falling half
  always_ff @(posedge mem_clk) begin
    if (mrst_s2_q) begin
      mphase_q         <= 1'b0;
      memory_clock_out <= 1'b0;
    end else begin
      mphase_q         <= ~mphase_q;
      // Clock falls on the step edge, so the memory samples mid-word
      memory_clock_out <= ~mphase_q;
    end
  end

  // ------------------------------------------------------------
  // Memory domain: request crossing and sequencer
  // ------------------------------------------------------------
  logic                   go_s1_q;
  logic                   go_s2_q;
  logic                   go_prev_q;
  rpx_pkg::rpx_req_type   op_q;
  rpx_pkg::rpx_state_type state_q;
  logic [10:0]            xfer_q;
  logic [`RPX_SRAM_AW-1:0] sram_adr_q;
  logic [`RPX_BUF_AW-1:0] a_adr_q;
  logic [`RPX_BUF_AW-1:0] b_adr_q;
  logic [2:0]             rd_pipe_q;
  logic                   wr_stage_q;
  logic                   wr_head_q;
  logic                   go_evt;
  logic                   rd_mode;
  logic                   issue;
  logic                   head;
  logic                   preload;
  logic                   inc_sram;
  logic                   inc_a;
  logic                   inc_b;
  logic                   dec_xfer;
  logic                   a_en;
  logic                   a_we;
  logic                   b_en;
  logic                   b_we;
  logic [`RPX_WORD_W-1:0] rdata_q;
  logic [`RPX_WORD_W-1:0] a_dout;
  logic [`RPX_WORD_W-1:0] b_dout;

  // Go toggle crosses as an event; request fields are stable by then
  always_ff @(posedge mem_clk) begin
    go_s1_q <= go_tgl_q;
    go_s2_q <= go_s1_q;
  end

  assign go_evt  = go_s2_q != go_prev_q;
  assign rd_mode = op_q.mode != `RPX_MODE_WBACK;
  assign issue   = state_q == rpx_pkg::RPX_ST_RUN;
  assign head    = (xfer_q[1:0] & `RPX_BURST_MASK) == `RPX_BURST_HEAD;

  // Counter strobes and buffer port roles per mode
  always_comb begin
    preload  = state_q == rpx_pkg::RPX_ST_LOAD;
    inc_sram = issue;
    dec_xfer = issue;
    inc_a    = 1'b0;
    inc_b    = 1'b0;
    a_en     = 1'b0;
    a_we     = 1'b0;
    b_en     = 1'b0;
    b_we     = 1'b0;
    unique case (op_q.mode)
      `RPX_MODE_COPY: begin
        b_en  = rd_pipe_q[`RPX_RD_VLD];
        b_we  = rd_pipe_q[`RPX_RD_VLD];
        inc_b = rd_pipe_q[`RPX_RD_VLD];
      end
      `RPX_MODE_XOR: begin
        b_en  = rd_pipe_q[`RPX_RD_CAP];
        inc_b = rd_pipe_q[`RPX_RD_CAP];
        a_en  = rd_pipe_q[`RPX_RD_VLD];
        a_we  = rd_pipe_q[`RPX_RD_VLD];
        inc_a = rd_pipe_q[`RPX_RD_VLD];
      end
      `RPX_MODE_WBACK: begin
        a_en  = issue;
        inc_a = issue;
      end
      `RPX_MODE_IDLE: begin
        inc_sram = 1'b0;
        dec_xfer = 1'b0;
      end
    endcase
  end

  // Sequencer: load, run 128 words back to back, drain, done
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      state_q    <= rpx_pkg::RPX_ST_IDLE;
      go_prev_q  <= go_s2_q;
      op_q       <= '0;
      done_tgl_q <= 1'b0;
    end else if (mphase_q) begin
      unique case (state_q)
        rpx_pkg::RPX_ST_IDLE: begin
          if (go_evt) begin
            go_prev_q <= go_s2_q;
            op_q      <= req_q;
            state_q   <= rpx_pkg::RPX_ST_LOAD;
          end
        end
        rpx_pkg::RPX_ST_LOAD: begin
          state_q <= rpx_pkg::RPX_ST_RUN;
        end
        rpx_pkg::RPX_ST_RUN: begin
          if (xfer_q == `RPX_XFER_ONE) begin
            state_q <= rpx_pkg::RPX_ST_DRAIN;
          end
        end
        rpx_pkg::RPX_ST_DRAIN: begin
          if (rd_pipe_q == '0 && !wr_stage_q) begin
            state_q <= rpx_pkg::RPX_ST_DONE;
          end
        end
        rpx_pkg::RPX_ST_DONE: begin
          done_tgl_q <= ~done_tgl_q;
          state_q    <= rpx_pkg::RPX_ST_IDLE;
        end
      endcase
    end
  end

  // SRAM address counter; linear bursts let it count by one
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      sram_adr_q <= '0;
    end else if (mphase_q && preload) begin
      sram_adr_q <= op_q.sram_base;
    end else if (mphase_q && inc_sram) begin
      sram_adr_q <= sram_adr_q + `RPX_SRAM_ONE;
    end
  end

  // Buffer port counters, both preloaded from the block base
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      a_adr_q <= '0;
      b_adr_q <= '0;
    end else if (mphase_q) begin
      if (preload) begin
        a_adr_q <= op_q.buf_base;
        b_adr_q <= op_q.buf_base;
      end else begin
        if (inc_a) begin
          a_adr_q <= a_adr_q + `RPX_BUF_ONE;
        end
        if (inc_b) begin
          b_adr_q <= b_adr_q + `RPX_BUF_ONE;
        end
      end
    end
  end

  // Transfer counter fixes every block at 128 words
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      xfer_q <= '0;
    end else if (mphase_q && preload) begin
      xfer_q <= `RPX_XFER_INIT;
    end else if (mphase_q && dec_xfer) begin
      xfer_q <= xfer_q - `RPX_XFER_ONE;
    end
  end

  // Read pipeline: launch, data on pads, registered word valid
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      rd_pipe_q <= '0;
    end else if (mphase_q) begin
      rd_pipe_q <= {rd_pipe_q[1:0], issue & rd_mode};
    end
  end

  // Memory data is registered before it meets the buffer
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      rdata_q <= '0;
    end else if (mphase_q && rd_pipe_q[`RPX_RD_CAP]) begin
      rdata_q <= pad_to_word(mem_dq_in);
    end
  end

  // Write stage waits one cycle for the buffer read
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      wr_stage_q <= 1'b0;
      wr_head_q  <= 1'b0;
    end else if (mphase_q) begin
      wr_stage_q <= issue & ~rd_mode;
      wr_head_q  <= head;
    end
  end

  // ------------------------------------------------------------
  // Memory pads, all launched from flops
  // ------------------------------------------------------------
  // New burst every fourth word keeps bursts gapless
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      mem_ce_n    <= 1'b1;
      mem_adv_n   <= 1'b1;
      mem_oe_n    <= 1'b1;
      mem_we_n    <= 1'b1;
      mem_addr    <= '0;
      bus_request <= 1'b0;
      bus_read    <= 1'b0;
    end else if (mphase_q) begin
      bus_request <= issue | wr_stage_q;
      bus_read    <= rd_mode;
      if (issue && rd_mode) begin
        mem_ce_n  <= ~head;
        mem_adv_n <= head;
        mem_we_n  <= 1'b1;
        mem_addr  <= sram_adr_q;
      end else if (wr_stage_q) begin
        mem_ce_n  <= ~wr_head_q;
        mem_adv_n <= wr_head_q;
        mem_we_n  <= 1'b0;
        mem_addr  <= sram_adr_q - `RPX_SRAM_ONE;
      end else begin
        mem_ce_n  <= 1'b1;
        mem_adv_n <= 1'b1;
        mem_we_n  <= 1'b1;
      end
      // Output enable spans launch until the last word is on the pads
      mem_oe_n <= ~((issue && rd_mode) || rd_pipe_q[0]);
    end
  end

  // Write data and its pad enable are registered together
  always_ff @(posedge mem_clk) begin
    if (mrst_q) begin
      mem_dq_out <= '0;
      mem_dq_oe  <= 1'b0;
    end else if (mphase_q) begin
      mem_dq_oe <= wr_stage_q;
      if (wr_stage_q) begin
        mem_dq_out <= word_to_pad(a_dout);
      end
    end
  end

  // ------------------------------------------------------------
  // Xor buffer
  // ------------------------------------------------------------
  // Strobes only count on the active phase, so ports follow it
  rpx_buffer u_buffer (
    .clk     (mem_clk),
    .a_en    (a_en & mphase_q),
    .a_we    (a_we),
    .a_adr   (a_adr_q),
    .b_en    (b_en & mphase_q),
    .b_we    (b_we),
    .b_adr   (b_adr_q),
    .b_wdata (rdata_q),
    .sram_q  (rdata_q),
    .a_dout  (a_dout),
    .b_dout  (b_dout)
  );

endmodule : rpx_engine
